/* rtl/mcg_map.svh */
// Register offsets, field positions, reset values and loop limits
`ifndef MCG_MAP_SVH
`define MCG_MAP_SVH
`define MCG_CFG_ADDR 8'h00
`define MCG_SYS_ADDR 8'h04
`define MCG_STAT_ADDR 8'h08
`define MCG_SRC_LSB 0
`define MCG_IDIV_LSB 2
`define MCG_ODIV_LSB 4
`define MCG_MUL_LSB 8
`define MCG_VB_LSB 13
`define MCG_SRC_LOOP 2'h3
`define MCG_VB_RSVD 2'h3
`define MCG_IDIV_MAX 2'h3
`define MCG_ODIV_MAX 4'hE
`define MCG_CFG_RST 15'h0000
`define MCG_VPER_RST 16'h0008
`define MCG_VB0_LO 16'h0006
`define MCG_VB0_HI 16'h0100
`define MCG_VB1_LO 16'h0004
`define MCG_VB1_HI 16'h00C0
`define MCG_VB2_LO 16'h0002
`define MCG_VB2_HI 16'h0080
`endif

/* rtl/mcg_pkg.sv */
// Types shared by the master clock generator
package mcg_pkg;
    typedef struct packed {
        logic [1:0] src;
        logic [1:0] idiv;
        logic [3:0] odiv;
        logic [4:0] mul;
        logic [1:0] vband;
    } mcg_cfg_t;

    typedef enum logic [1:0] {
        LS_BYPASS,
        LS_ACQUIRE,
        LS_LOCKED
    } mcg_lock_t;

    typedef struct packed {
        logic master_tick;
        logic cpu_tick;
        logic sys_tick;
        logic master_lvl;
    } mcg_clk_t;
endpackage : mcg_pkg

/* rtl/mcg_top.sv */
// Master clock generator with bypass prescalers and digital loop
// Functional notes
// - Two-bit source field: upper bit zero bypasses, both bits set runs loop.
// - Bypass master rate is oscillator over (idiv+1) times (odiv+1).
// - With both dividers zero, bypass passes oscillator level straight through.
// - Input divider limited to 3, output divider limited to 14.
// - Loop master rate is oscillator times (mul+1) over divider product.
// - Loop adjusts its period by one step at a time, never abruptly.
// - Loop master clock is VCO ticks divided by odiv+1.
// - Two-bit VCO band selects period range; pattern 11 is reserved.
// - CPU clock runs at master rate or half, set by one bit.
// - CPU and bus unit use CPU clock; system clock has same rate.
`timescale 1ns/10ps
`include "mcg_map.svh"
module mcg_top (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Oscillator
    input wire logic OSC_IN,
    // Generated clocks
    output logic MASTER_CLK,
    output logic MASTER_TICK,
    output logic CPU_TICK,
    output logic SYS_TICK,
    output logic LOCKED
);
    mcg_pkg::mcg_cfg_t cfg_q, cfg_d;
    logic halve_q, halve_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] rdata_q, rdata_d;

    logic osc_q, osc_d;
    logic [1:0] ref_cnt_q, ref_cnt_d;
    logic [15:0] vper_q, vper_d;
    logic [15:0] vcnt_q, vcnt_d;
    logic [3:0] ocnt_q, ocnt_d;
    logic [15:0] tcount_q, tcount_d;
    logic phase_q, phase_d;
    mcg_pkg::mcg_lock_t lock_q, lock_d;
    mcg_pkg::mcg_clk_t clk_q, clk_d;
    logic locked_q, locked_d;

    logic osc_rise;
    logic ref_tick;
    logic vco_tick;
    logic pass_thru;
    logic loop_mode;
    logic [15:0] vlo;
    logic [15:0] vhi;
    logic [15:0] want;
    logic [15:0] wdiv;

    // Bus and register group
    always_comb begin
        cfg_d = cfg_q;
        halve_d = halve_q;
        rdata_d = rdata_q;
        wr_pend_d = 1'b0;
        wr_addr_d = wr_addr_q;
        wdiv = 16'h0000;
        if (wr_pend_q) begin
            if (wr_addr_q == `MCG_CFG_ADDR) begin
                cfg_d.src = HWDATA[`MCG_SRC_LSB +: 2];
                cfg_d.idiv = HWDATA[`MCG_IDIV_LSB +: 2];
                wdiv = {12'h000, HWDATA[`MCG_ODIV_LSB +: 4]};
                // Out-of-range divider clamps to the slowest ratio
                cfg_d.odiv = (wdiv[3:0] > `MCG_ODIV_MAX) ?
                    `MCG_ODIV_MAX : wdiv[3:0];
                cfg_d.mul = HWDATA[`MCG_MUL_LSB +: 5];
                // Reserved band pattern is ignored, old band kept
                if (HWDATA[`MCG_VB_LSB +: 2] != `MCG_VB_RSVD) begin
                    cfg_d.vband = HWDATA[`MCG_VB_LSB +: 2];
                end
            end else if (wr_addr_q == `MCG_SYS_ADDR) begin
                halve_d = HWDATA[0];
            end
        end
        if (HSEL && HREADY && HTRANS[1]) begin
            wr_pend_d = HWRITE;
            wr_addr_d = HADDR;
            case (HADDR)
                `MCG_CFG_ADDR: rdata_d = {17'h0_0000, cfg_q.vband, cfg_q.mul,
                    cfg_q.odiv, cfg_q.idiv, cfg_q.src};
                `MCG_SYS_ADDR: rdata_d = {31'h0000_0000, halve_q};
                `MCG_STAT_ADDR: rdata_d = {vper_q, 14'h0000,
                    lock_q == mcg_pkg::LS_LOCKED, loop_mode};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            cfg_q <= `MCG_CFG_RST;
            halve_q <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end else begin
            cfg_q <= cfg_d;
            halve_q <= halve_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q <= rdata_d;
        end
    end

    // Clock generation group
    always_comb begin
        loop_mode = (cfg_q.src == `MCG_SRC_LOOP);
        pass_thru = !cfg_q.src[1] && cfg_q.idiv == 2'h0 &&
            cfg_q.odiv == 4'h0;
        osc_d = OSC_IN;
        osc_rise = OSC_IN && !osc_q;
        ref_cnt_d = ref_cnt_q;
        ref_tick = 1'b0;
        // Input prescaler shared by both modes
        if (osc_rise) begin
            if (ref_cnt_q >= cfg_q.idiv) begin
                ref_cnt_d = 2'h0;
                ref_tick = 1'b1;
            end else begin
                ref_cnt_d = ref_cnt_q + 2'h1;
            end
        end
        case (cfg_q.vband)
            2'h1: begin
                vlo = `MCG_VB1_LO;
                vhi = `MCG_VB1_HI;
            end
            2'h2: begin
                vlo = `MCG_VB2_LO;
                vhi = `MCG_VB2_HI;
            end
            default: begin
                vlo = `MCG_VB0_LO;
                vhi = `MCG_VB0_HI;
            end
        endcase
        want = {11'h000, cfg_q.mul} + 16'h0001;
        vper_d = vper_q;
        vcnt_d = vcnt_q;
        vco_tick = 1'b0;
        tcount_d = tcount_q;
        lock_d = lock_q;
        if (loop_mode) begin
            // Free-running VCO, one tick per vper_q cycles
            if (vcnt_q + 16'h0001 >= vper_q) begin
                vcnt_d = 16'h0000;
                vco_tick = 1'b1;
            end else begin
                vcnt_d = vcnt_q + 16'h0001;
            end
            if (lock_q == mcg_pkg::LS_BYPASS) begin
                lock_d = mcg_pkg::LS_ACQUIRE;
            end
            if (ref_tick) begin
                tcount_d = {15'h0000, vco_tick};
                // Single-step slew keeps the frequency change smooth
                if (tcount_q > want && vper_q < vhi) begin
                    vper_d = vper_q + 16'h0001;
                end else if (tcount_q < want && vper_q > vlo) begin
                    vper_d = vper_q - 16'h0001;
                end
                lock_d = (tcount_q == want) ?
                    mcg_pkg::LS_LOCKED : mcg_pkg::LS_ACQUIRE;
            end else if (vco_tick && tcount_q != 16'hFFFF) begin
                tcount_d = tcount_q + 16'h0001;
            end
        end else begin
            lock_d = mcg_pkg::LS_BYPASS;
            tcount_d = 16'h0000;
            vcnt_d = 16'h0000;
        end
        locked_d = (lock_d == mcg_pkg::LS_LOCKED);
        ocnt_d = ocnt_q;
        clk_d.master_tick = 1'b0;
        // Output prescaler counts VCO ticks or input-prescaled edges
        if (loop_mode ? vco_tick : (ref_tick && !cfg_q.src[1])) begin
            if (ocnt_q >= cfg_q.odiv) begin
                ocnt_d = 4'h0;
                clk_d.master_tick = 1'b1;
            end else begin
                ocnt_d = ocnt_q + 4'h1;
            end
        end
        clk_d.master_lvl = pass_thru ? OSC_IN : clk_d.master_tick;
        phase_d = phase_q;
        if (clk_d.master_tick) begin
            phase_d = !phase_q;
        end
        // Enables only, so a halving change cannot shorten a pulse
        clk_d.cpu_tick = clk_d.master_tick && (!halve_q || phase_q);
        clk_d.sys_tick = clk_d.cpu_tick;
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            // Track the pin in reset, so a high level is no false edge
            osc_q <= osc_d;
            ref_cnt_q <= 2'h0;
            vper_q <= `MCG_VPER_RST;
            vcnt_q <= 16'h0000;
            ocnt_q <= 4'h0;
            tcount_q <= 16'h0000;
            phase_q <= 1'b0;
            lock_q <= mcg_pkg::LS_BYPASS;
            clk_q <= '0;
            locked_q <= 1'b0;
        end else begin
            osc_q <= osc_d;
            ref_cnt_q <= ref_cnt_d;
            vper_q <= vper_d;
            vcnt_q <= vcnt_d;
            ocnt_q <= ocnt_d;
            tcount_q <= tcount_d;
            phase_q <= phase_d;
            lock_q <= lock_d;
            clk_q <= clk_d;
            locked_q <= locked_d;
        end
    end

    // Outputs straight from flops; HREADYOUT and HRESP are tied to constants
    assign HRDATA = rdata_q;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign MASTER_CLK = clk_q.master_lvl;
    assign MASTER_TICK = clk_q.master_tick;
    assign CPU_TICK = clk_q.cpu_tick;
    assign SYS_TICK = clk_q.sys_tick;
    assign LOCKED = locked_q;
endmodule : mcg_top

/* dv/mcg_chk_sva.sv */
// Port checker for the master clock generator
`timescale 1ns/10ps
module mcg_chk (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // Bus
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // Clocks
    input wire logic OSC_IN,
    input wire logic MASTER_CLK,
    input wire logic MASTER_TICK,
    input wire logic CPU_TICK,
    input wire logic SYS_TICK,
    input wire logic LOCKED
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    logic tk;
    logic dirty_q;
    logic dirty_d;
    assign tk = HSEL && HREADY && HTRANS[1];
    // Untouched config since reset means pass-through
    always_comb begin
        dirty_d = !SRST && (dirty_q || (tk && HWRITE && HADDR == 8'h00));
    end
    always_ff @(posedge CLOCK) begin
        dirty_q <= dirty_d;
    end
    AST_READY: assert property (HREADYOUT) else $error("wait state seen");
    AST_RESP: assert property (!HRESP) else $error("error response seen");
    AST_SYS_CPU: assert property (SYS_TICK == CPU_TICK)
        else $error("system tick differs from cpu tick");
    AST_CPU_IN_MC: assert property (CPU_TICK |-> MASTER_TICK)
        else $error("cpu tick without master tick");
    AST_RST_QUIET: assert property (disable iff (1'b0)
        SRST |=> !LOCKED && !MASTER_TICK && HRDATA == 32'h0)
        else $error("outputs active after reset");
    AST_PASS_LVL: assert property (!dirty_q && !$past(SRST) |->
        MASTER_CLK == $past(OSC_IN)) else $error("pass-through level");
    AST_PASS_TICK: assert property (!dirty_q |-> MASTER_TICK ==
        ($past(OSC_IN) && !$past(OSC_IN, 2))) else $error("tick slip");
    AST_RDATA_HOLD: assert property (!tk |=> $stable(HRDATA))
        else $error("read data moved without transfer");
    AST_LOCK_MODE: assert property (LOCKED |-> dirty_q)
        else $error("locked in reset configuration");
    cover property (LOCKED);
    cover property (MASTER_TICK && dirty_q);
    cover property (MASTER_TICK && !CPU_TICK);
endmodule : mcg_chk
bind mcg_top mcg_chk mcg_chk_i (.*);

/* dv/mcg_top_tb.sv */
// Self-checking bench for the master clock generator
`timescale 1ns/10ps
module mcg_top_tb;
    logic CLOCK = 0, SRST = 1, HSEL = 1, HWRITE = 0, OSC_IN = 0;
    logic [7:0] HADDR = 8'h0;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h0;
    logic [31:0] HWDATA = 32'h0, HRDATA, d;
    logic HREADYOUT, HRESP, MASTER_CLK, MASTER_TICK, CPU_TICK;
    logic SYS_TICK, LOCKED;
    int n_errors = 0, total_checks = 0, cyc = 0, oh = 2, oc = 0, m, c;
    mcg_top mcg_top_i (.CLOCK(CLOCK), .SRST(SRST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .OSC_IN(OSC_IN),
        .MASTER_CLK(MASTER_CLK), .MASTER_TICK(MASTER_TICK),
        .CPU_TICK(CPU_TICK), .SYS_TICK(SYS_TICK), .LOCKED(LOCKED));
    initial begin
        forever #5 CLOCK = ~CLOCK;
    end
    // Oscillator half period is oh cycles, held at its current level in reset
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        oc <= (SRST || oc + 1 >= oh) ? 0 : oc + 1;
        if (!SRST && oc + 1 >= oh) OSC_IN <= ~OSC_IN;
        // Ceiling well above the slowest lock search
        if (cyc > 20000) begin
            n_errors++;
            end_sim;
        end
    end
    task automatic chk(input logic [31:0] g, e);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic tol(input logic [31:0] g, input int e);
        chk((g + 1 >= e && g <= e + 1) ? e : g, e);
    endtask : tol
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= w;
        HSIZE <= 3'h2;
        @(posedge CLOCK);
        while (HREADYOUT !== 1'b1) @(posedge CLOCK);
        HTRANS <= 2'h0;
        HWDATA <= wd;
        @(posedge CLOCK);
        while (HREADYOUT !== 1'b1) @(posedge CLOCK);
        d = HRDATA;
    endtask : bus
    task automatic cnt(input int n);
        m = 0;
        c = 0;
        repeat (n) begin
            @(posedge CLOCK);
            m += MASTER_TICK === 1'b1;
            c += CPU_TICK === 1'b1 && SYS_TICK === 1'b1;
        end
    endtask : cnt
    task automatic t_pass;
        cnt(240);
        tol(m, 60);
        tol(c, 60);
        bus(1, 8'h04, 32'h1);
        cnt(240);
        tol(c, 30);
        bus(1, 8'h04, 32'h0);
    endtask : t_pass
    task automatic t_byp;
        logic [7:0] t [4] = '{8'h05, 8'h20, 8'hEC, 8'h02};
        int r;
        foreach (t[k]) begin
            r = 2 * oh * (t[k][3:2] + 1) * (t[k][7:4] + 1);
            bus(1, 8'h00, {24'h0, t[k]});
            bus(0, 8'h00, 32'h0);
            chk(d, {24'h0, t[k]});
            cnt(r);
            cnt(4 * r);
            tol(m, t[k][1] ? 0 : 4);
        end
        bus(1, 8'h00, 32'h00F0);
        bus(0, 8'h00, 32'h0);
        chk(d, 32'h00E0);
    endtask : t_byp
    task automatic t_band;
        for (int b = 0; b < 4; b++) begin
            bus(1, 8'h00, b << 13);
            bus(0, 8'h00, 32'h0);
            chk(d, (b == 3 ? 2 : b) << 13);
        end
        bus(0, 8'h0C, 32'h0);
        chk(d, 32'h0);
    endtask : t_band
    // Ref period 32 and two vco ticks per ref: period settles at 16
    task automatic t_loop;
        int p = 8;
        oh = 16;
        bus(1, 8'h00, 32'h0113);
        // Lock may flicker on below the target period, so wait for both
        repeat (2000) begin
            bus(0, 8'h08, 32'h0);
            tol(d[31:16], p);
            p = d[31:16];
            if (d[1] && d[31:16] == 16'h0010) break;
        end
        chk(d, 32'h0010_0003);
        cnt(320);
        tol(m, 10);
        chk(LOCKED, 1'b1);
        bus(0, 8'h08, 32'h0);
        chk(d, 32'h0010_0003);
    endtask : t_loop
    // Mid-run reset out of loop mode back to pass-through
    task automatic t_rst;
        SRST <= 1'b1;
        repeat (2) @(posedge CLOCK);
        SRST <= 1'b0;
        @(posedge CLOCK);
        chk(LOCKED, 1'b0);
        bus(0, 8'h00, 32'h0);
        chk(d, 32'h0000_0000);
        bus(0, 8'h04, 32'h0);
        chk(d, 32'h0000_0000);
        bus(0, 8'h08, 32'h0);
        chk(d, 32'h0008_0000);
        cnt(320);
        tol(m, 10);
        tol(c, 10);
    endtask : t_rst
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    initial begin
        repeat (4) @(posedge CLOCK);
        SRST <= 1'b0;
        repeat (8) @(posedge CLOCK);
        t_pass;
        t_byp;
        t_band;
        t_loop;
        t_rst;
        end_sim;
    end
endmodule : mcg_top_tb
